// ==== hw/cbt_consts.svh ====
// Offsets, field positions and reset values of the built-in down timer
`ifndef CBT_CONSTS_SVH
`define CBT_CONSTS_SVH

// =====================================================================
// Register offsets (byte addresses)
`define CBT_OFS_CTRL 8'h00
`define CBT_OFS_PRELOAD 8'h04
`define CBT_OFS_COUNT 8'h08
`define CBT_OFS_DIV 8'h0c
`define CBT_OFS_PSW 8'h10
`define CBT_OFS_EVT 8'h14
`define CBT_OFS_MASK 8'h18

// =====================================================================
// Field positions
`define CBT_CTRL_RUN 0
`define CBT_CTRL_MODE 1
`define CBT_PSW_TU 12
`define CBT_PSW_IP 13
`define CBT_EVT_ZERO 0
`define CBT_EVT_TIRQ 1

// =====================================================================
// Reset values and event field width
`define CBT_DIV_RST 16'h0001
`define CBT_MASK_RST 2'h2
`define CBT_EVT_W 2

`endif

// ==== hw/cbt_pkg.sv ====
// Types shared by the built-in down timer
`default_nettype none
package cbt_pkg;
    // Operating mode of the timer
    typedef enum logic {
        CBT_COUNTDOWN = 1'b0,
        CBT_INTERRUPT = 1'b1
    } cbt_mode_e;
endpackage : cbt_pkg
`default_nettype wire

// ==== hw/cbt_timer.sv ====
// Built-in down timer of the processor core with its register port
//
// Operation
// - Two modes: plain count-down or interrupt on expiry
// - Decrement once every divider cycles after start
// - Count-down mode halts at zero, wraps only after a control write sets run in the expiry cycle
// - Underflow sets status word bit 12
// - Interrupt mode counts alike, interrupts at zero
// - Interrupt processing flag reads one while servicing
`timescale 1ns/100ps
`default_nettype none
`include "cbt_consts.svh"

module cbt_timer
    import cbt_pkg::*;
#(
    parameter int CNT_W = 32,
    parameter int DIV_W = 16
) (
    // Clock, reset and clock enable
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic ce,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // Core interrupt sequencing
    input wire logic irq_enter,
    input wire logic irq_exit,
    // Interrupt request
    output logic irq
);

    // =================================================================
    // State
    logic run;
    cbt_mode_e mode;
    logic [CNT_W-1:0] count;
    logic [DIV_W-1:0] div;
    logic [DIV_W-1:0] presc;
    logic tu_flag;
    logic ip_flag;
    logic [`CBT_EVT_W-1:0] evt;
    logic [`CBT_EVT_W-1:0] mask;

    logic next_run;
    cbt_mode_e next_mode;
    logic [CNT_W-1:0] next_count;
    logic [DIV_W-1:0] next_div;
    logic [DIV_W-1:0] next_presc;
    logic next_tu_flag;
    logic next_ip_flag;
    logic [`CBT_EVT_W-1:0] next_evt;
    logic [`CBT_EVT_W-1:0] next_mask;
    logic [31:0] next_rdata;
    logic next_irq;

    logic tick;
    logic expire;
    logic [DIV_W-1:0] div_last;

    // Write strobe decode for one register
    function automatic logic wr_hit(input logic [7:0] ofs);
        wr_hit = reg_wr && (reg_addr == ofs);
    endfunction : wr_hit

    // =================================================================
    // Prescaler and expiry detection
    always_comb begin
        div_last = (div == '0) ? '0 : div - 1'b1; // A zero divider acts as one
        tick = run && (presc == div_last);
        expire = tick && (count == {{(CNT_W-1){1'b0}}, 1'b1});
    end

    // =================================================================
    // Timer control and counter next state
    always_comb begin
        next_run = run;
        next_mode = mode;
        next_count = count;
        next_div = div;
        next_presc = presc;
        if (run) begin
            next_presc = tick ? '0 : presc + 1'b1;
        end
        if (tick) begin
            next_count = count - 1'b1;
            if (expire) begin
                next_run = 1'b0;
            end
        end
        if (wr_hit(`CBT_OFS_CTRL)) begin
            next_mode = cbt_mode_e'(reg_wdata[`CBT_CTRL_MODE]);
            next_run = reg_wdata[`CBT_CTRL_RUN] && (count != '0);
            next_presc = '0;
        end
        if (wr_hit(`CBT_OFS_PRELOAD)) begin
            next_count = reg_wdata[CNT_W-1:0];
            next_presc = '0;
            next_run = run && (reg_wdata[CNT_W-1:0] != '0);
        end
        if (wr_hit(`CBT_OFS_DIV)) begin
            next_div = reg_wdata[DIV_W-1:0];
            next_presc = '0;
        end
    end

    // Timer control and counter registers, frozen while ce is low
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            run <= 1'b0;
            mode <= CBT_COUNTDOWN;
            count <= '0;
            div <= DIV_W'(`CBT_DIV_RST);
            presc <= '0;
        end else if (ce) begin
            run <= next_run;
            mode <= next_mode;
            count <= next_count;
            div <= next_div;
            presc <= next_presc;
        end
    end

    // =================================================================
    // Status word flags, events and mask next state
    always_comb begin
        next_tu_flag = tu_flag;
        next_ip_flag = ip_flag;
        next_evt = evt;
        next_mask = mask;
        // Software clears the underflow flag by writing one to it
        if (wr_hit(`CBT_OFS_PSW) && reg_wdata[`CBT_PSW_TU]) begin
            next_tu_flag = 1'b0;
        end
        if (expire) begin
            next_tu_flag = 1'b1;
        end
        // Servicing state follows the core entry and exit strobes
        if (irq_exit) begin
            next_ip_flag = 1'b0;
        end
        if (irq_enter) begin
            next_ip_flag = 1'b1;
        end
        // A read of the event register clears it; new events win
        if (reg_rd && (reg_addr == `CBT_OFS_EVT)) begin
            next_evt = '0;
        end
        if (expire) begin
            next_evt[`CBT_EVT_ZERO] = 1'b1;
        end
        if (expire && (mode == CBT_INTERRUPT)) begin
            next_evt[`CBT_EVT_TIRQ] = 1'b1;
        end
        if (wr_hit(`CBT_OFS_MASK)) begin
            next_mask = reg_wdata[`CBT_EVT_W-1:0];
        end
    end

    // Status word flags, events and mask registers
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            tu_flag <= 1'b0;
            ip_flag <= 1'b0;
            evt <= '0;
            mask <= `CBT_EVT_W'(`CBT_MASK_RST);
        end else if (ce) begin
            tu_flag <= next_tu_flag;
            ip_flag <= next_ip_flag;
            evt <= next_evt;
            mask <= next_mask;
        end
    end

    // =================================================================
    // Read data and interrupt output
    always_comb begin
        next_rdata = '0;
        if (reg_rd) begin
            unique case (reg_addr)
                `CBT_OFS_CTRL: begin
                    next_rdata[`CBT_CTRL_RUN] = run;
                    next_rdata[`CBT_CTRL_MODE] = mode;
                end
                `CBT_OFS_PRELOAD, `CBT_OFS_COUNT: begin
                    next_rdata[CNT_W-1:0] = count;
                end
                `CBT_OFS_DIV: begin
                    next_rdata[DIV_W-1:0] = div;
                end
                `CBT_OFS_PSW: begin
                    next_rdata[`CBT_PSW_TU] = tu_flag;
                    next_rdata[`CBT_PSW_IP] = ip_flag;
                end
                `CBT_OFS_EVT: begin
                    next_rdata[`CBT_EVT_W-1:0] = evt;
                end
                `CBT_OFS_MASK: begin
                    next_rdata[`CBT_EVT_W-1:0] = mask;
                end
                default: begin
                    next_rdata = '0; // Unmapped offsets read zero
                end
            endcase
        end
        next_irq = |(next_evt & next_mask);
    end

    // Read data and interrupt output registers
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= '0;
            irq <= 1'b0;
        end else if (ce) begin
            reg_rdata <= next_rdata;
            irq <= next_irq;
        end
    end

endmodule : cbt_timer
`default_nettype wire

// ==== tb/cbt_timer_properties.sv ====
// Port checker of the built-in down timer
`timescale 1ns/100ps
`default_nettype none
module cbt_timer_chk (
    // Clock, reset and clock enable
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic ce,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    // Interrupt side
    input wire logic irq_enter,
    input wire logic irq_exit,
    input wire logic irq
);
    // ==========
    // Access decodes
    wire logic rd_psw = ce && reg_rd && reg_addr == 8'h10;
    wire logic rd_cnt = ce && reg_rd && reg_addr == 8'h08;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    a_ip_set: assert property (ce && irq_enter ##1 rd_psw |=> reg_rdata[13])
        else $error("flag not set");
    a_ip_clr: assert property (ce && irq_exit && !irq_enter ##1 rd_psw |=> !reg_rdata[13])
        else $error("flag not cleared");
    a_tu_sticky: assert property (rd_psw ##1 (rd_psw && reg_rdata[12]) |=> reg_rdata[12])
        else $error("underflow lost");
    a_count_step: assert property (rd_cnt ##1 rd_cnt |=> reg_rdata == $past(reg_rdata)
        || ($past(reg_rdata) != 0 && reg_rdata == $past(reg_rdata) - 32'h1))
        else $error("bad count step");
    a_count_load: assert property (ce && reg_wr && reg_addr == 8'h04 ##2 rd_cnt |=>
        reg_rdata == $past(reg_wdata, 3) || reg_rdata == $past(reg_wdata, 3) - 32'h1)
        else $error("preload not taken");
    a_mask_off: assert property (ce && reg_wr && reg_addr == 8'h18 && reg_wdata[1:0] == 2'h0 |=> !irq)
        else $error("masked irq");
    a_tu_irq: assert property ($rose(irq) && !$past(reg_wr) && rd_psw |=> reg_rdata[12])
        else $error("irq without underflow");
endmodule : cbt_timer_chk
bind cbt_timer cbt_timer_chk u_chk (.core_clk(core_clk), .rst_n(rst_n), .ce(ce),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .irq_enter(irq_enter), .irq_exit(irq_exit), .irq(irq));
`default_nettype wire

// ==== tb/cbt_timer_tb_top.sv ====
// Self-checking bench of the built-in down timer
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin errors++; \
    $display("[FAIL] %0t got %h want %h", $time, a, b); end end
module cbt_timer_tb_top;
    logic core_clk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, irq_enter = 0, irq_exit = 0, irq;
    logic ce = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0, reg_rdata;
    int errors = 0, samples_checked = 0, hit;
    // ==========
    // Clock and device
    initial begin
        forever #2 core_clk = ~core_clk;
    end
    cbt_timer dut (.core_clk(core_clk), .rst_n(rst_n), .ce(ce), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .irq_enter(irq_enter), .irq_exit(irq_exit), .irq(irq));
    // ==========
    // Register access
    task wr(input logic [7:0] a, input logic [31:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        @(posedge core_clk);
    endtask : wr
    task rd(input logic [7:0] a, input logic [31:0] e);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        @(negedge core_clk);
        `CHK(reg_rdata, e)
        @(posedge core_clk);
    endtask : rd
    // Reads one place on eight cycles back to back, notes first cycle with irq
    task poll(input logic [7:0] a);
        hit = -1;
        reg_addr <= a;
        reg_rd <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            @(negedge core_clk);
            if (irq === 1'b1 && hit < 0) hit = i;
        end
        @(posedge core_clk);
        reg_rd <= 1'b0;
        @(posedge core_clk);
    endtask : poll
    task wrap_up();
        if (errors == 0 && samples_checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : wrap_up
    // ==========
    // Main sequence
    initial begin
        repeat (8) @(posedge core_clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 8; i++) rd(8'(4 * i), i == 3 ? 32'h1 : i == 6 ? 32'h2 : 32'h0);
        // Count-down mode halts at zero with no interrupt
        wr(8'h04, 32'h3);
        wr(8'h00, 32'h1);
        poll(8'h08);
        `CHK(hit, -1)
        rd(8'h08, 32'h0);
        rd(8'h14, 32'h1);
        rd(8'h10, 32'h1000);
        wr(8'h10, 32'h1000);
        rd(8'h10, 32'h0);
        wr(8'h04, 32'h9);
        rd(8'h08, 32'h9);
        // Clock enable low freezes the running count, then stop it
        wr(8'h00, 32'h1);
        ce <= 1'b0;
        repeat (4) @(posedge core_clk);
        ce <= 1'b1;
        rd(8'h08, 32'h8);
        wr(8'h00, 32'h0);
        // Interrupt mode with divider three
        wr(8'h0c, 32'h3);
        wr(8'h04, 32'h2);
        wr(8'h00, 32'h3);
        poll(8'h10);
        `CHK(hit, 5)
        `CHK(irq, 1'b1)
        wr(8'h18, 32'h0);
        `CHK(irq, 1'b0)
        rd(8'h14, 32'h3);
        wr(8'h18, 32'h2);
        `CHK(irq, 1'b0)
        // Service flag follows entry and exit
        irq_enter <= 1'b1;
        @(posedge core_clk);
        irq_enter <= 1'b0;
        rd(8'h10, 32'h3000);
        irq_exit <= 1'b1;
        @(posedge core_clk);
        irq_exit <= 1'b0;
        rd(8'h10, 32'h1000);
        // Reset after the timer halts at zero clears the status word and restores the divider
        rst_n <= 1'b0;
        repeat (2) @(posedge core_clk);
        rst_n <= 1'b1;
        rd(8'h10, 32'h0);
        rd(8'h0c, 32'h1);
        wrap_up();
    end
endmodule : cbt_timer_tb_top
`default_nettype wire
